// ### hw/snmpaf_params.svh
// Purpose: constants of the request filter and agent front end
// Assumes: 10 MHz core clock, apb register access
// Notes: register offsets are byte addresses
// How it works
// - answer only requests to local ip
// - source must match one of five stations
// - udp destination must equal agent port
// - community exact bytes, up to 63
// - one community for reads and writes
// - first char selects slot 1-9, A-C
// - slot prefix needs at-sign, then community
// - agent is slot zero or bare community
// - console serial 9600 baud 8N1
// - masked destination equals masked gateway means local
// - local goes direct, else via gateway
// - console transmit line held idle high, nothing shown
// - traps use configured trap port
// - each trap copied to every configured station
// - trap on either power supply failure
// - get to slot zero returns contact, location, name strings
// - network link 10 or 100 Mb/s
// - enter raises a one-cycle menu request, no menu printed
`ifndef SNMPAF_PARAMS_SVH
`define SNMPAF_PARAMS_SVH
`define SNMPAF_CLK_HZ 10000000
`define SNMPAF_BAUD 9600
`define SNMPAF_BAUD_DIV ((`SNMPAF_CLK_HZ + `SNMPAF_BAUD / 2) / `SNMPAF_BAUD)
`define SNMPAF_NUM_STATIONS 5
`define SNMPAF_MAX_STR 63
`define SNMPAF_NUM_SLOTS 12
`define SNMPAF_OFS_LOCAL_IP 12'h000
`define SNMPAF_OFS_STATION0 12'h004
`define SNMPAF_OFS_GATEWAY 12'h018
`define SNMPAF_OFS_MASK 12'h01c
`define SNMPAF_OFS_PORTS 12'h020
`define SNMPAF_OFS_COMM_LEN 12'h024
`define SNMPAF_OFS_STATUS 12'h028
`define SNMPAF_OFS_PSU 12'h02c
`define SNMPAF_OFS_COMM 12'h100
`define SNMPAF_OFS_CONTACT 12'h200
`define SNMPAF_OFS_LOCATION 12'h300
`define SNMPAF_OFS_NAME 12'h400
`define SNMPAF_RST_IP 32'hffffffff
`define SNMPAF_RST_MASK 32'h00000000
`define SNMPAF_RST_AGENT_PORT 16'h00a1
`define SNMPAF_RST_TRAP_PORT 16'h00a2
`define SNMPAF_AT_SIGN 8'h40
`define SNMPAF_CR 8'h0d
`endif

// ### hw/snmpaf_pkg.sv
// Purpose: types of the request filter
// Assumes: nothing
// Notes: none
package snmpaf_pkg;
   typedef enum logic [1:0] {SNMPAF_CHK_IDLE, SNMPAF_CHK_BYTES, SNMPAF_CHK_DONE} snmpaf_chk_type;
   typedef enum logic [1:0] {SNMPAF_TRAP_IDLE, SNMPAF_TRAP_SEND, SNMPAF_TRAP_WAIT} snmpaf_trap_type;
   typedef enum logic [1:0] {SNMPAF_STR_CONTACT, SNMPAF_STR_LOCATION, SNMPAF_STR_NAME, SNMPAF_STR_NONE} snmpaf_str_type;
endpackage

// ### hw/snmpaf_agent_filter.sv
// Purpose: snmp agent request admission, slot routing, reply routing, traps
// Assumes: request header fields arrive parallel, community as byte stream
// Notes: console serial port receives enter and emits a menu event only
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
`include "snmpaf_params.svh"
module snmpaf_agent_filter
   import snmpaf_pkg::*;
#(
   parameter int STATIONS = `SNMPAF_NUM_STATIONS,
   parameter int MAXSTR = `SNMPAF_MAX_STR
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reqStart,
   input wire logic [31:0] reqDstIp,
   input wire logic [31:0] reqSrcIp,
   input wire logic [15:0] reqDstPort,
   input wire logic [1:0] reqGetString,
   input wire logic commValid,
   input wire logic [7:0] commByte,
   input wire logic commLast,
   output logic reqAccept,
   output logic reqDrop,
   output logic [3:0] reqSlot,
   output logic [2:0] reqStation,
   output logic [1:0] reqString,
   input wire logic [31:0] destIp,
   output logic destLocal,
   output logic [31:0] nextHopIp,
   input wire logic [3:0] strIndex,
   input wire logic [5:0] strAddr,
   output logic [7:0] strByte,
   input wire logic moduleTrap,
   input wire logic [1:0] psuFail,
   output logic trapValid,
   output logic [31:0] trapDstIp,
   output logic [15:0] trapDstPort,
   input wire logic trapReady,
   input wire logic consoleRx,
   output logic consoleTx,
   output logic menuRequest
);
   // ======================================
   // configuration storage
   logic [31:0] localIp;
   logic [31:0] stationIp [STATIONS];
   logic [31:0] gatewayIp;
   logic [31:0] subnetMask;
   logic [15:0] agentPort;
   logic [15:0] trapPort;
   logic [5:0] commLen;
   logic [7:0] commMem [64];
   logic [7:0] contactMem [64];
   logic [7:0] locationMem [64];
   logic [7:0] nameMem [64];
   logic [1:0] psuSeen;
   logic [2:0] lastStation;
   logic lastLocal;
   logic lastAccept;
   logic [3:0] lastSlot;

   function automatic logic sameSubnet(input logic [31:0] a, input logic [31:0] g, input logic [31:0] m);
      return (a & m) == (g & m);
   endfunction

   wire logic wrEn = psel && penable && pwrite;
   wire logic [3:0] region = paddr[11:8];
   wire logic [5:0] memIdx = paddr[7:2];
   wire logic [2:0] stIdx = 3'((paddr - `SNMPAF_OFS_STATION0) >> 2);
   wire logic stSel = paddr >= `SNMPAF_OFS_STATION0 && paddr < `SNMPAF_OFS_GATEWAY && paddr[1:0] == 2'b00;

   // ======================================
   // apb slave
   assign pready = 1'b1;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         localIp <= `SNMPAF_RST_IP;
         gatewayIp <= `SNMPAF_RST_IP;
         subnetMask <= `SNMPAF_RST_MASK;
         agentPort <= `SNMPAF_RST_AGENT_PORT;
         trapPort <= `SNMPAF_RST_TRAP_PORT;
         commLen <= 6'h00;
         for (int i = 0; i < STATIONS; i++)
            stationIp[i] <= `SNMPAF_RST_IP;
      end
      else if (wrEn)
      begin
         if (paddr == `SNMPAF_OFS_LOCAL_IP)
            localIp <= pwdata;
         if (stSel)
            stationIp[stIdx] <= pwdata;
         if (paddr == `SNMPAF_OFS_GATEWAY)
            gatewayIp <= pwdata;
         if (paddr == `SNMPAF_OFS_MASK)
            subnetMask <= pwdata;
         if (paddr == `SNMPAF_OFS_PORTS)
         begin
            agentPort <= pwdata[15:0];
            trapPort <= pwdata[31:16];
         end
         if (paddr == `SNMPAF_OFS_COMM_LEN)
            commLen <= (pwdata > 32'(MAXSTR)) ? 6'(MAXSTR) : pwdata[5:0];
      end
   end

   // string memories, no reset
   always_ff @(posedge core_clk)
   begin
      if (wrEn)
      begin
         case (region)
            4'h1: commMem[memIdx] <= pwdata[7:0];
            4'h2: contactMem[memIdx] <= pwdata[7:0];
            4'h3: locationMem[memIdx] <= pwdata[7:0];
            4'h4: nameMem[memIdx] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   logic mapped;
   logic [31:0] rdMux;
   always_comb
   begin
      mapped = 1'b1;
      rdMux = 32'h00000000;
      case (region)
         4'h0:
         begin
            if (paddr == `SNMPAF_OFS_LOCAL_IP)
               rdMux = localIp;
            else if (stSel)
               rdMux = stationIp[stIdx];
            else if (paddr == `SNMPAF_OFS_GATEWAY)
               rdMux = gatewayIp;
            else if (paddr == `SNMPAF_OFS_MASK)
               rdMux = subnetMask;
            else if (paddr == `SNMPAF_OFS_PORTS)
               rdMux = {trapPort, agentPort};
            else if (paddr == `SNMPAF_OFS_COMM_LEN)
               rdMux = {26'h0, commLen};
            else if (paddr == `SNMPAF_OFS_STATUS)
               rdMux = {21'h0, lastLocal, lastSlot, lastStation, lastAccept, 2'b00};
            else if (paddr == `SNMPAF_OFS_PSU)
               rdMux = {30'h0, psuSeen};
            else
               mapped = 1'b0;
         end
         4'h1: rdMux = {24'h0, commMem[memIdx]};
         4'h2: rdMux = {24'h0, contactMem[memIdx]};
         4'h3: rdMux = {24'h0, locationMem[memIdx]};
         4'h4: rdMux = {24'h0, nameMem[memIdx]};
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= rdMux; // loaded in setup so data stands through access
   end

   // ======================================
   // header checks, latched at request start
   logic hdrOk;
   logic [2:0] hitStation;
   logic anyHit;
   always_comb
   begin
      anyHit = 1'b0;
      hitStation = 3'h0;
      for (int i = STATIONS - 1; i >= 0; i--)
      begin
         if (stationIp[i] == reqSrcIp && stationIp[i] != `SNMPAF_RST_IP)
         begin
            anyHit = 1'b1;
            hitStation = 3'(i);
         end
      end
   end

   // ======================================
   // community matcher: accepts bare, 0@ or slot@ prefix
   snmpaf_chk_type chkState;
   logic [6:0] pos;
   logic bareOk;
   logic preOk;
   logic [3:0] preSlot;
   logic [1:0] strSel;

   function automatic logic [4:0] slotOf(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39)
         return {1'b1, 4'(c - 8'h30)};
      else if (c >= 8'h41 && c <= 8'h43)
         return {1'b1, 4'(c - 8'h37)};
      else
         return 5'h00;
   endfunction

   wire logic [4:0] firstSlot = slotOf(commByte);
   wire logic [5:0] preIdx = 6'(pos - 7'd2);
   wire logic bareMatch = pos < 7'(commLen) && commByte == commMem[pos[5:0]];
   wire logic preMatch = pos >= 7'd2 && preIdx < commLen && commByte == commMem[preIdx];

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chkState <= SNMPAF_CHK_IDLE;
         pos <= 7'h00;
         bareOk <= 1'b0;
         preOk <= 1'b0;
         preSlot <= 4'h0;
         hdrOk <= 1'b0;
         strSel <= 2'b11;
         lastStation <= 3'h0;
      end
      else
      begin
         case (chkState)
            SNMPAF_CHK_IDLE:
            begin
               if (reqStart)
               begin
                  hdrOk <= reqDstIp == localIp && anyHit && reqDstPort == agentPort;
                  lastStation <= hitStation;
                  strSel <= reqGetString;
                  pos <= 7'h00;
                  bareOk <= 1'b1;
                  preOk <= 1'b1;
                  chkState <= SNMPAF_CHK_BYTES;
               end
            end
            SNMPAF_CHK_BYTES:
            begin
               if (commValid)
               begin
                  bareOk <= bareOk && bareMatch;
                  if (pos == 7'd0)
                  begin
                     preOk <= firstSlot[4];
                     preSlot <= firstSlot[3:0];
                  end
                  else if (pos == 7'd1)
                     preOk <= preOk && commByte == `SNMPAF_AT_SIGN;
                  else
                     preOk <= preOk && preMatch;
                  if (pos < 7'd66)
                     pos <= pos + 7'd1;
                  if (commLast)
                     chkState <= SNMPAF_CHK_DONE;
               end
            end
            SNMPAF_CHK_DONE: chkState <= SNMPAF_CHK_IDLE;
            default: chkState <= SNMPAF_CHK_IDLE;
         endcase
      end
   end

   // full length checked at completion; pos is total byte count
   wire logic bareFull = bareOk && pos == 7'(commLen);
   wire logic preFull = preOk && pos == 7'(commLen) + 7'd2;
   wire logic passAll = hdrOk && (bareFull || preFull);

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reqAccept <= 1'b0;
         reqDrop <= 1'b0;
         reqSlot <= 4'h0;
         reqStation <= 3'h0;
         reqString <= 2'b11;
         lastAccept <= 1'b0;
         lastSlot <= 4'h0;
      end
      else
      begin
         reqAccept <= chkState == SNMPAF_CHK_DONE && passAll;
         reqDrop <= chkState == SNMPAF_CHK_DONE && !passAll;
         if (chkState == SNMPAF_CHK_DONE)
         begin
            reqSlot <= bareFull ? 4'h0 : preSlot;
            reqStation <= lastStation;
            reqString <= (passAll && (bareFull || preSlot == 4'h0)) ? strSel : 2'b11;
            lastAccept <= passAll;
            lastSlot <= bareFull ? 4'h0 : preSlot;
         end
      end
   end

   // ======================================
   // reply routing and string readout
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         destLocal <= 1'b0;
         nextHopIp <= 32'h00000000;
         lastLocal <= 1'b0;
         strByte <= 8'h00;
      end
      else
      begin
         destLocal <= sameSubnet(destIp, gatewayIp, subnetMask);
         nextHopIp <= sameSubnet(destIp, gatewayIp, subnetMask) ? destIp : gatewayIp;
         if (reqAccept)
            lastLocal <= sameSubnet(stationIp[reqStation], gatewayIp, subnetMask);
         case (snmpaf_str_type'(strIndex[1:0]))
            SNMPAF_STR_CONTACT: strByte <= contactMem[strAddr];
            SNMPAF_STR_LOCATION: strByte <= locationMem[strAddr];
            SNMPAF_STR_NAME: strByte <= nameMem[strAddr];
            default: strByte <= 8'h00;
         endcase
      end
   end

   // ======================================
   // trap fan-out to all configured stations
   snmpaf_trap_type trapState;
   logic [2:0] trapIdx;
   logic trapPend;
   logic [1:0] psuPrev;
   wire logic psuEvent = |(psuFail & ~psuPrev);
   wire logic trapCause = moduleTrap || psuEvent;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         trapState <= SNMPAF_TRAP_IDLE;
         trapIdx <= 3'h0;
         trapPend <= 1'b0;
         psuPrev <= 2'b00;
         psuSeen <= 2'b00;
         trapValid <= 1'b0;
         trapDstIp <= 32'h00000000;
         trapDstPort <= 16'h0000;
      end
      else
      begin
         psuPrev <= psuFail;
         psuSeen <= psuSeen | psuFail;
         if (trapCause)
            trapPend <= 1'b1;
         case (trapState)
            SNMPAF_TRAP_IDLE:
            begin
               if (trapPend || trapCause)
               begin
                  trapPend <= 1'b0;
                  trapIdx <= 3'h0;
                  trapState <= SNMPAF_TRAP_SEND;
               end
            end
            SNMPAF_TRAP_SEND:
            begin
               if (int'(trapIdx) >= STATIONS)
                  trapState <= SNMPAF_TRAP_IDLE;
               else if (stationIp[trapIdx] == `SNMPAF_RST_IP)
                  trapIdx <= trapIdx + 3'h1;
               else
               begin
                  trapValid <= 1'b1;
                  trapDstIp <= stationIp[trapIdx];
                  trapDstPort <= trapPort;
                  trapState <= SNMPAF_TRAP_WAIT;
               end
            end
            SNMPAF_TRAP_WAIT:
            begin
               if (trapReady)
               begin
                  trapValid <= 1'b0;
                  trapIdx <= trapIdx + 3'h1;
                  trapState <= SNMPAF_TRAP_SEND;
               end
            end
            default: trapState <= SNMPAF_TRAP_IDLE;
         endcase
      end
   end

   // ======================================
   // console receiver, 8N1; enter raises menu request
   logic [11:0] baudCnt;
   logic [3:0] bitCnt;
   logic [7:0] rxShift;
   logic rxBusy;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         baudCnt <= 12'h000;
         bitCnt <= 4'h0;
         rxShift <= 8'h00;
         rxBusy <= 1'b0;
         menuRequest <= 1'b0;
      end
      else
      begin
         menuRequest <= 1'b0;
         if (!rxBusy)
         begin
            if (!consoleRx)
            begin
               rxBusy <= 1'b1;
               baudCnt <= 12'(`SNMPAF_BAUD_DIV / 2);
               bitCnt <= 4'h0;
            end
         end
         else if (baudCnt == 12'h000)
         begin
            baudCnt <= 12'(`SNMPAF_BAUD_DIV - 1);
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt >= 4'h1 && bitCnt <= 4'h8)
               rxShift <= {consoleRx, rxShift[7:1]};
            if (bitCnt == 4'h9)
            begin
               rxBusy <= 1'b0;
               menuRequest <= consoleRx && rxShift == `SNMPAF_CR;
            end
         end
         else
            baudCnt <= baudCnt - 12'h001;
      end
   end

   assign consoleTx = 1'b1;
endmodule // snmpaf_agent_filter

// ### sim/snmpaf_filter_assertions.sv
// Purpose: concurrent checks on the request filter ports
// Assumes: apb writes land at the access edge
// Notes: shadows gateway, mask and trap port from apb writes
`timescale 1ns/100ps
`include "snmpaf_params.svh"
module snmpaf_filter_checker
#(
   parameter int STATIONS = 5,
   parameter int MAXSTR = 63
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic commValid,
   input wire logic commLast,
   input wire logic reqAccept,
   input wire logic reqDrop,
   input wire logic [31:0] destIp,
   input wire logic destLocal,
   input wire logic [31:0] nextHopIp,
   input wire logic moduleTrap,
   input wire logic [1:0] psuFail,
   input wire logic trapValid,
   input wire logic [31:0] trapDstIp,
   input wire logic [15:0] trapDstPort,
   input wire logic trapReady,
   input wire logic consoleTx,
   input wire logic menuRequest
);
   logic [31:0] gw, mask, expHop;
   logic [15:0] trapPort;
   logic expLocal;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // shadow configuration
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gw <= `SNMPAF_RST_IP;
         mask <= `SNMPAF_RST_MASK;
         trapPort <= `SNMPAF_RST_TRAP_PORT;
      end
      else if (psel && penable && pwrite)
      begin
         if (paddr == `SNMPAF_OFS_GATEWAY) gw <= pwdata;
         if (paddr == `SNMPAF_OFS_MASK) mask <= pwdata;
         if (paddr == `SNMPAF_OFS_PORTS) trapPort <= pwdata[31:16];
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         expLocal <= 1'b0;
         expHop <= 32'h0;
      end
      else
      begin
         expLocal <= (destIp & mask) == (gw & mask);
         expHop <= ((destIp & mask) == (gw & mask)) ? destIp : gw;
      end
   end
   // ==========
   // properties
   property p_local; destLocal == expLocal; endproperty
   property p_hop; nextHopIp == expHop; endproperty
   property p_verdict; commValid && commLast |-> ##2 (reqAccept ^ reqDrop); endproperty
   property p_quiet; reqAccept || reqDrop |-> $past(commLast, 2); endproperty
   property p_pulse; reqAccept || reqDrop |=> !reqAccept && !reqDrop; endproperty
   property p_tport; trapValid |-> trapDstPort == trapPort; endproperty
   property p_thold; trapValid && !trapReady |=> trapValid && $stable(trapDstIp); endproperty
   property p_tdst; trapValid |-> trapDstIp != 32'hffffffff; endproperty
   property p_tstart; ($rose(psuFail[0]) || $rose(psuFail[1]) || moduleTrap) && !trapValid |-> ##[1:3] trapValid;
   endproperty
   property p_ctx; consoleTx; endproperty
   a_local: assert property (p_local) else $error("local decision wrong");
   a_hop: assert property (p_hop) else $error("next hop wrong");
   a_verdict: assert property (p_verdict) else $error("no verdict");
   a_quiet: assert property (p_quiet) else $error("verdict without request");
   a_pulse: assert property (p_pulse) else $error("verdict longer than a cycle");
   a_tport: assert property (p_tport) else $error("trap port wrong");
   a_thold: assert property (p_thold) else $error("trap dropped before ready");
   a_tdst: assert property (p_tdst) else $error("trap to unused station");
   a_tstart: assert property (p_tstart) else $error("trap not raised");
   a_ctx: assert property (p_ctx) else $error("console line not idle");
   c_acc: cover property (reqAccept);
   c_drop: cover property (reqDrop);
   c_trap: cover property (trapValid && trapReady);
   c_menu: cover property (menuRequest);
endmodule // snmpaf_filter_checker

bind snmpaf_agent_filter snmpaf_filter_checker #(.STATIONS(STATIONS), .MAXSTR(MAXSTR)) u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .commValid(commValid), .commLast(commLast),
   .reqAccept(reqAccept), .reqDrop(reqDrop), .destIp(destIp), .destLocal(destLocal),
   .nextHopIp(nextHopIp), .moduleTrap(moduleTrap), .psuFail(psuFail), .trapValid(trapValid),
   .trapDstIp(trapDstIp), .trapDstPort(trapDstPort), .trapReady(trapReady),
   .consoleTx(consoleTx), .menuRequest(menuRequest));

// ### sim/snmpaf_station_model.sv
// Purpose: management station model, sends requests and takes traps
// Assumes: one request at a time
// Notes: released lines carry inverted values
`timescale 1ns/100ps
module snmpaf_station_model
(
   input wire logic core_clk,
   output logic reqStart,
   output logic [31:0] reqDstIp,
   output logic [31:0] reqSrcIp,
   output logic [15:0] reqDstPort,
   output logic [1:0] reqGetString,
   output logic commValid,
   output logic [7:0] commByte,
   output logic commLast,
   input wire logic trapValid,
   input wire logic [31:0] trapDstIp,
   output logic trapReady
);
   int stall = 1;
   int tick = 0;
   logic [31:0] trapLog[$];
   initial
   begin
      {reqStart, commValid, commLast, trapReady} = 4'h0;
      {reqDstIp, reqSrcIp, reqDstPort, reqGetString, commByte} = 90'h0;
   end
   // header held only for the start edge
   task automatic send(input logic [31:0] dst, input logic [31:0] src, input logic [15:0] port,
                       input logic [1:0] gs, input string c);
      @(posedge core_clk);
      reqStart <= 1'b1;
      reqDstIp <= dst;
      reqSrcIp <= src;
      reqDstPort <= port;
      reqGetString <= gs;
      for (int i = 0; i < c.len(); i++)
      begin
         @(posedge core_clk);
         reqStart <= 1'b0;
         {reqDstIp, reqSrcIp, reqDstPort} <= ~{dst, src, port};
         commValid <= 1'b1;
         commByte <= c[i];
         commLast <= (i == c.len() - 1);
      end
      @(posedge core_clk);
      commValid <= 1'b0;
      commLast <= 1'b0;
      commByte <= ~commByte;
   endtask
   // slow receiver: ready one cycle in stall
   always @(posedge core_clk)
   begin
      if (trapValid && trapReady)
         trapLog.push_back(trapDstIp);
      tick <= tick + 1;
      trapReady <= (tick % stall) == 0;
   end
endmodule // snmpaf_station_model

// ### sim/tb_snmp_agent_request_filter.sv
// Purpose: self-checking bench of the agent request filter
// Assumes: apb answers with zero wait states
// Notes: community bytes one per word
`timescale 1ns/100ps
`include "snmpaf_params.svh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin numErrors++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_snmp_agent_request_filter;
   logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, reqStart, commValid, commLast, serr;
   logic reqAccept, reqDrop, destLocal, moduleTrap, trapValid, trapReady, consoleRx, consoleTx, menuRequest;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata, reqDstIp, reqSrcIp, destIp, nextHopIp, trapDstIp;
   logic [15:0] reqDstPort, trapDstPort;
   logic [1:0] reqGetString, reqString, psuFail;
   logic [7:0] commByte, strByte;
   logic [3:0] reqSlot, strIndex;
   logic [2:0] reqStation;
   logic [5:0] strAddr;
   int numErrors = 0, nChecks = 0, menuSeen = 0;
   string cm = "pU\001", sc = "123456789ABC";
   localparam logic [31:0] ME = 32'hc0a80064, S0 = 32'hc0a8000b, S2 = 32'hc0a8000a, GW = 32'hc0a80001;
   localparam logic [15:0] P = 16'h04d2;
   snmpaf_agent_filter dut (.*);
   snmpaf_station_model m (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (menuRequest === 1'b1) menuSeen++;
   // ==========
   // access tasks
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      serr = pslverr;
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdata, e)
   endtask
   task rq(input logic [31:0] dst, input logic [31:0] src, input logic [15:0] port, input logic [1:0] gs,
           input string c, input logic acc, input logic [3:0] slot = 4'h0, input logic [2:0] st = 3'h0);
      int k;
      k = 0;
      m.send(dst, src, port, gs, c);
      do begin @(posedge core_clk); #1; end while (!(reqAccept | reqDrop) && ++k < 8);
      `CHK({reqAccept, reqDrop}, {acc, !acc})
      if (acc) `CHK({reqSlot, reqStation, reqString}, {slot, st, (slot == 4'h0) ? gs : 2'h3})
   endtask
   task lat(input logic [31:0] ip, input logic loc, input logic [31:0] hop);
      @(posedge core_clk);
      destIp <= ip;
      @(posedge core_clk);
      #1 `CHK({destLocal, nextHopIp}, {loc, hop})
   endtask
   task trap(input logic mt, input logic [1:0] pf);
      int k;
      k = 0;
      m.trapLog.delete();
      @(posedge core_clk);
      moduleTrap <= mt;
      psuFail <= pf;
      @(posedge core_clk);
      moduleTrap <= 1'b0;
      while (m.trapLog.size() < 2 && ++k < 100) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      `CHK({m.trapLog.size() == 2, m.trapLog[0], m.trapLog[1]}, {1'b1, S0, S2})
   endtask
   task uart(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge core_clk);
         consoleRx <= f[i];
         repeat (`SNMPAF_BAUD_DIV - 1) @(posedge core_clk);
      end
      repeat (2 * `SNMPAF_BAUD_DIV) @(posedge core_clk);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========
   // tests
   initial
   begin
      {sys_rst, consoleRx, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
      {destIp, strIndex, strAddr, moduleTrap, psuFail} = 45'h0;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(`SNMPAF_OFS_LOCAL_IP, 32'hffffffff);
      rd(`SNMPAF_OFS_PORTS, 32'h00a200a1);
      rd(`SNMPAF_OFS_MASK, 32'h0);
      rd(12'h800, 32'h0);
      `CHK(serr, 1'b1)
      $display("test reset done");
      apb(1'b1, `SNMPAF_OFS_LOCAL_IP, ME);
      apb(1'b1, `SNMPAF_OFS_STATION0, S0);
      apb(1'b1, `SNMPAF_OFS_STATION0 + 12'h8, S2);
      apb(1'b1, `SNMPAF_OFS_PORTS, {16'h00c8, P});
      apb(1'b1, `SNMPAF_OFS_GATEWAY, GW);
      apb(1'b1, `SNMPAF_OFS_MASK, 32'hffff0000);
      for (int i = 0; i < 3; i++) apb(1'b1, `SNMPAF_OFS_COMM + 12'(4 * i), {24'h0, cm[i]});
      apb(1'b1, `SNMPAF_OFS_COMM_LEN, 32'h3);
      apb(1'b1, `SNMPAF_OFS_NAME + 12'h4, 32'h7a);
      rq(ME, S0, P, 2'h0, cm, 1'b1);
      rq(ME, S2, P, 2'h2, {"0@", cm}, 1'b1, 4'h0, 3'h2);
      for (int i = 0; i < 12; i++) rq(ME, S0, P, 2'h1, $sformatf("%c@%s", sc[i], cm), 1'b1, 4'(i + 1));
      rq(ME, S0, P, 2'h0, {"c@", cm}, 1'b0);
      rq(ME, S0, P, 2'h0, {"1#", cm}, 1'b0);
      rq(ME, S0, P, 2'h0, "pu\001", 1'b0);
      rq(ME, S0, P, 2'h0, "pU", 1'b0);
      rq(ME, S0, P, 2'h0, {cm, "x"}, 1'b0);
      rq(ME + 32'h1, S0, P, 2'h0, cm, 1'b0);
      rq(ME, S0 + 32'h1, P, 2'h0, cm, 1'b0);
      rq(ME, 32'hffffffff, P, 2'h0, cm, 1'b0);
      rq(ME, S0, 16'd161, 2'h0, cm, 1'b0);
      rd(`SNMPAF_OFS_STATUS, 32'h400);
      $display("test requests done");
      @(posedge core_clk);
      strIndex <= 4'h2;
      strAddr <= 6'h1;
      @(posedge core_clk);
      #1 `CHK(strByte, 8'h7a)
      lat(32'hc0a80036, 1'b1, 32'hc0a80036);
      lat(32'h0a000001, 1'b0, GW);
      apb(1'b1, `SNMPAF_OFS_MASK, 32'h0);
      lat(32'h0a000001, 1'b1, 32'h0a000001);
      $display("test routing done");
      m.stall = 3;
      trap(1'b1, 2'b00);
      trap(1'b0, 2'b01);
      trap(1'b0, 2'b11);
      rd(`SNMPAF_OFS_PSU, 32'h3);
      $display("test traps done");
      uart(8'h41);
      `CHK(menuSeen, 0)
      uart(`SNMPAF_CR);
      `CHK(menuSeen, 1)
      $display("test console done");
      finish_test;
   end
   initial
   begin
      #6000000;
      numErrors++;
      finish_test;
   end
endmodule // tb_snmp_agent_request_filter
